/* File: src/pgt_timer.sv */
`include "pgt_params.svh"

// Functional notes
// - intervals 100 ms to 7200 s between successive gate falling edges
// - mode high: timer mode, gate low at each interval start
// - gate output is active low; low turns the MOSFET on
// - without done, low pulse lasts interval minus 50 ms
// - gate idles high during reading; the first pulse starts as reading ends
// - each low pulse launches when an interval begins
// - only a rising edge on done counts as a done event
// - only the first done per interval acts; later ones ignored
// - accepted done drives gate high at once
// - interval measured once after reset, never repeated
// - measurement phase typically 100 ms, at most 120 ms
// - after reading, enter timer or one-shot mode from static mode pin
// - mode low: exactly one low pulse after start-up
// - in one-shot, each valid manual event gives one more pulse
// - manual high during reset or reading aborts and restarts reading
// - manual valid only if high at least 20 ms within 30 ms
// - manual input debounced on both edges
// - after valid manual, gate low within 10 ms for interval minus 50 ms
// - manual clears counters; they resume once pin returns low
// - while manual held high, gate stays low and done is ignored
// - manual ignored while gate already low
// - pin read as manual only after the reading ends
module pgt_timer #(
  parameter int unsigned CLK_HZ   = `PGT_CLK_HZ,  // core clock rate
  parameter int unsigned TICK_CYC = CLK_HZ / 1000 // cycles per ms tick
) (
  input  wire logic               core_clk,            // 40 MHz clock
  input  wire logic               resetn,              // async reset, active low
  input  wire logic               mode_select,         // high timer, low one-shot
  input  wire logic               done,                // done pin
  input  wire logic               interval_set_manual_on, // shared pin, digital view
  input  wire pgt_pkg::pgt_interval_t digitised,       // digitiser code and strobe
  output logic                    readActive,          // analog reading in progress
  output logic                    readRestart,         // high while pin high during reading: restart digitiser
  output logic                    gate_drive_n         // MOSFET gate, active low
);
  localparam logic [31:0] GUARD_TK = 32'(`PGT_OFF_GUARD_MS / `PGT_TICK_MS);
  localparam logic [31:0] READ_MAX_TK = 32'(`PGT_READ_MAX_MS / `PGT_TICK_MS);
  localparam logic [31:0] OBS_TK = 32'(`PGT_MANUAL_OBS_MS / `PGT_TICK_MS);
  localparam logic [31:0] VALID_TK = 32'(`PGT_MANUAL_VALID_MS / `PGT_TICK_MS);

  function automatic logic [31:0] code_to_ticks(input logic [16:0] c);
    logic [16:0] k;
    k = (c < 17'(`PGT_CODE_MIN)) ? 17'(`PGT_CODE_MIN) :
        (c > 17'(`PGT_CODE_MAX)) ? 17'(`PGT_CODE_MAX) : c;
    code_to_ticks = 32'(k) * 32'(`PGT_CODE_UNIT_MS / `PGT_TICK_MS);
  endfunction

  pgt_pkg::pgt_state_t state;
  logic        tick;
  logic        doneS1, doneS2, donePrev;
  logic        pinS1, pinS2;
  logic        modeS1, modeS2;
  logic        manualLevel, manualPrev;
  logic [31:0] period;
  logic [31:0] elapsed;
  logic [31:0] readTimer;
  logic [31:0] obsTimer, highTimer;
  logic        doneTaken;
  logic        doneEdge, manualRise, manualValid;
  logic        pinForManual;

  pgt_tick_gen #(.TICK_CYCLES(TICK_CYC)) u_tick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick)
  );

  // pin and done arrive asynchronously
  // done chain resets high: a done strapped high must not look like an edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      doneS1   <= 1'b1;
      doneS2   <= 1'b1;
      donePrev <= 1'b1;
      pinS1    <= 1'b0;
      pinS2    <= 1'b0;
      modeS1   <= 1'b0;
      modeS2   <= 1'b0;
    end else begin
      doneS1   <= done;
      doneS2   <= doneS1;
      donePrev <= doneS2;
      pinS1    <= interval_set_manual_on;
      pinS2    <= pinS1;
      modeS1   <= mode_select;
      modeS2   <= modeS1;
    end
  end

  assign doneEdge = doneS2 && !donePrev;

  // during reading the pin is analog; only a strong high is seen here
  assign pinForManual = pinS2;

  pgt_debounce #(.HOLD_TICKS(`PGT_DEBOUNCE_MS / `PGT_TICK_MS)) u_deb (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick),
    .rawIn    (pinForManual),
    .level    (manualLevel)
  );

  // validity window: counts pin-high ticks per 30 ms; manualValid checks it only as highTimer <= OBS_TK
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      obsTimer  <= 32'h0;
      highTimer <= 32'h0;
    end else if (!pinS2 && obsTimer == 32'h0) begin
      highTimer <= 32'h0;
    end else if (tick) begin
      if (obsTimer >= OBS_TK - 32'h1) begin
        obsTimer  <= 32'h0;
        highTimer <= 32'h0;
      end else begin
        obsTimer  <= obsTimer + 32'h1;
        highTimer <= highTimer + (pinS2 ? 32'h1 : 32'h0);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      manualPrev <= 1'b0;
    end else begin
      manualPrev <= manualLevel;
    end
  end

  assign manualRise  = manualLevel && !manualPrev;
  // debounce hold equals the 20 ms minimum, observed inside 30 ms
  assign manualValid = manualRise && (highTimer <= OBS_TK) &&
                       (state != pgt_pkg::ST_READ);

  assign readActive = (state == pgt_pkg::ST_READ);

  // abort while pin high; digitiser restarts on release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      readTimer   <= 32'h0;
      readRestart <= 1'b0;
    end else if (state == pgt_pkg::ST_READ && pinS2) begin
      readTimer   <= 32'h0;
      readRestart <= 1'b1;
    end else begin
      readRestart <= 1'b0;
      if (state == pgt_pkg::ST_READ && tick && readTimer < READ_MAX_TK) begin
        readTimer <= readTimer + 32'h1;
      end
    end
  end

  // period fixed once; a missing strobe by 120 ms keeps the minimum code, 100 ms
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      period <= code_to_ticks(17'(`PGT_CODE_MIN));
    end else if (state == pgt_pkg::ST_READ && !pinS2 && digitised.valid) begin
      period <= code_to_ticks(digitised.code);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= pgt_pkg::ST_READ;
      elapsed   <= 32'h0;
      doneTaken <= 1'b0;
    end else begin
      unique case (state)
        pgt_pkg::ST_READ: begin
          if (!pinS2 && (digitised.valid || readTimer >= READ_MAX_TK)) begin
            elapsed   <= 32'h0;
            doneTaken <= 1'b0;
            state     <= pgt_pkg::ST_ON;
          end
        end
        pgt_pkg::ST_IDLE: begin
          if (manualValid) begin
            state <= pgt_pkg::ST_MANUAL;
          end
        end
        pgt_pkg::ST_ON: begin
          if (tick) begin
            elapsed <= elapsed + 32'h1;
          end
          if (doneEdge && !doneTaken) begin
            doneTaken <= 1'b1;
            state     <= pgt_pkg::ST_GUARD;
          end else if (tick && elapsed + 32'h1 >= period - GUARD_TK) begin
            state <= pgt_pkg::ST_GUARD;
          end
        end
        pgt_pkg::ST_GUARD: begin
          if (manualValid) begin
            state <= pgt_pkg::ST_MANUAL;
          end else if (tick) begin
            if (elapsed + 32'h1 >= period) begin
              elapsed   <= 32'h0;
              doneTaken <= 1'b0;
              state     <= modeS2 ? pgt_pkg::ST_ON
                                       : pgt_pkg::ST_IDLE;
            end else begin
              elapsed <= elapsed + 32'h1;
            end
          end
        end
        pgt_pkg::ST_MANUAL: begin
          elapsed   <= 32'h0;
          doneTaken <= 1'b0;
          state     <= pgt_pkg::ST_WAITREL;
        end
        pgt_pkg::ST_WAITREL: begin
          // counters held clear and done ignored while pin high
          elapsed   <= 32'h0;
          doneTaken <= 1'b0;
          if (!manualLevel) begin
            state <= pgt_pkg::ST_ON;
          end
        end
        default: state <= pgt_pkg::ST_READ;
      endcase
    end
  end

  // manual request in ST_ON is never looked at
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gate_drive_n <= 1'b1;
    end else begin
      gate_drive_n <= !(state == pgt_pkg::ST_ON || state == pgt_pkg::ST_MANUAL ||
                        state == pgt_pkg::ST_WAITREL);
    end
  end

  sequence s_read_exit;
    readActive && !pinS2 && (digitised.valid || readTimer >= READ_MAX_TK);
  endsequence

  // gate register lags the state by one edge, hence the extra cycle
  launch_read_a : assert property (@(posedge core_clk) disable iff (!resetn)
    s_read_exit |=> ##1 !gate_drive_n)
    else $error("gate not launched after reading");

  read_exit_a : assert property (@(posedge core_clk) disable iff (!resetn)
    s_read_exit |=> state == pgt_pkg::ST_ON)
    else $error("reading end did not start a pulse");

  on_hold_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_ON && !doneEdge && !tick) |=> state == pgt_pkg::ST_ON)
    else $error("on-window left without edge or tick");

  edge_pulse_a : assert property (@(posedge core_clk) disable iff (!resetn)
    doneEdge |=> !doneEdge)
    else $error("done level seen as repeated edge");

  wait_hold_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_WAITREL && manualLevel) |=> state == pgt_pkg::ST_WAITREL)
    else $error("manual hold left while pin high");

  manual_launch_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_IDLE && manualValid) |=> ##1 !gate_drive_n)
    else $error("manual pulse not launched");

  manual_clear_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_MANUAL) |=> (elapsed == 32'h0 && state == pgt_pkg::ST_WAITREL))
    else $error("counters not cleared by manual");

  read_once_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state != pgt_pkg::ST_READ) |=> state != pgt_pkg::ST_READ)
    else $error("reading repeated during operation");

  on_window_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_ON) |-> elapsed < period)
    else $error("on-window overran interval");

  guard_window_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_GUARD) |-> elapsed < period)
    else $error("interval overran");

  timer_repeat_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_GUARD && tick && !manualValid && elapsed + 32'h1 >= period &&
     modeS2) |=> state == pgt_pkg::ST_ON)
    else $error("timer mode did not repeat");

  oneshot_stop_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_GUARD && tick && !manualValid && elapsed + 32'h1 >= period &&
     !modeS2) |=> state == pgt_pkg::ST_IDLE)
    else $error("one-shot mode repeated");

  idle_gate_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_IDLE) |=> gate_drive_n)
    else $error("gate low while idle");

  restart_pulse_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (readActive && !pinS2) |=> !readRestart)
    else $error("restart without manual");

  read_manual_a : assert property (@(posedge core_clk) disable iff (!resetn)
    readActive |-> !manualValid)
    else $error("manual accepted during reading");

  sequence s_done_edge;
    state == pgt_pkg::ST_ON && doneEdge && !doneTaken;
  endsequence

  done_turnoff_a : assert property (@(posedge core_clk) disable iff (!resetn)
    s_done_edge |=> ##1 gate_drive_n)
    else $error("gate not released after done");

  done_once_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_ON && doneTaken) |-> 1'b0)
    else $error("second done acted within interval");

  read_idle_high_a : assert property (@(posedge core_clk) disable iff (!resetn)
    readActive |=> gate_drive_n)
    else $error("gate low during reading");

  read_abort_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (readActive && pinS2) |=> (readRestart && readTimer == 32'h0))
    else $error("reading not aborted by manual");

  manual_hold_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_WAITREL) |=> ##1 !gate_drive_n)
    else $error("gate released while manual held");

  manual_ignore_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_ON && manualValid) |=> state != pgt_pkg::ST_MANUAL)
    else $error("manual acted while gate low");

  guard_off_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_GUARD) |=> gate_drive_n)
    else $error("gate low in final guard");

  oneshot_idle_a : assert property (@(posedge core_clk) disable iff (!resetn)
    (state == pgt_pkg::ST_IDLE && !manualValid) |=> ##1 gate_drive_n)
    else $error("one-shot produced extra pulse");

  read_bound_a : assert property (@(posedge core_clk) disable iff (!resetn)
    readTimer <= READ_MAX_TK)
    else $error("reading exceeded limit");
endmodule

/* File: src/pgt_params.svh */
`ifndef PGT_PARAMS_SVH
`define PGT_PARAMS_SVH

// time base: one ms tick divided down from the core clock
`define PGT_TICK_MS          1
// interval code is in 100 ms units: 1 .. 72000
`define PGT_CODE_UNIT_MS     100
`define PGT_CODE_MIN         1
`define PGT_CODE_MAX         72000
`define PGT_OFF_GUARD_MS     50
`define PGT_READ_TYP_MS      100
`define PGT_READ_MAX_MS      120
`define PGT_MANUAL_VALID_MS  20
`define PGT_MANUAL_OBS_MS    30
`define PGT_MANUAL_LAT_MS    10
`define PGT_DEBOUNCE_MS      20
`define PGT_DONE_MIN_NS      100
`define PGT_CLK_HZ           40000000
`define PGT_CLK_NS           25

`endif

/* File: src/pgt_pkg.sv */
package pgt_pkg;
  typedef enum logic [2:0] {
    ST_READ,
    ST_IDLE,
    ST_ON,
    ST_GUARD,
    ST_MANUAL,
    ST_WAITREL
  } pgt_state_t;

  typedef struct packed {
    logic [16:0] code;
    logic        valid;
  } pgt_interval_t;
endpackage

/* File: src/pgt_tick_gen.sv */
`include "pgt_params.svh"

module pgt_tick_gen #(
  parameter int unsigned TICK_CYCLES = (`PGT_CLK_HZ / 1000) * `PGT_TICK_MS
) (
  input  wire logic core_clk, // system clock
  input  wire logic resetn,   // async reset, active low
  output logic      tick      // one-cycle pulse per ms
);
  logic [31:0] count;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count >= TICK_CYCLES - 1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule

/* File: src/pgt_debounce.sv */
`include "pgt_params.svh"

module pgt_debounce #(
  parameter int unsigned HOLD_TICKS = `PGT_DEBOUNCE_MS / `PGT_TICK_MS
) (
  input  wire logic core_clk, // system clock
  input  wire logic resetn,   // async reset, active low
  input  wire logic tick,     // ms tick
  input  wire logic rawIn,    // synchronised pin level
  output logic      level     // debounced level
);
  logic [7:0] stable;

  // both edges must hold for the full count; glitches restart it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stable <= 8'h00;
      level  <= 1'b0;
    end else if (rawIn == level) begin
      stable <= 8'h00;
    end else if (tick) begin
      if (stable >= 8'(HOLD_TICKS - 1)) begin
        level  <= rawIn;
        stable <= 8'h00;
      end else begin
        stable <= stable + 8'h01;
      end
    end
  end
endmodule

/* File: testbench/pgt_mcu_model.sv */
// supplied microcontroller: answers with done pulses while powered
module pgt_mcu_model (
  input  wire logic        core_clk,     // system clock
  input  wire logic        gate_drive_n, // supply gate, low = powered
  input  wire logic [15:0] doneAfter,    // cycles to first done, 0 never
  input  wire logic        doneHold,     // done strapped high
  output logic             done          // done pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0;
  initial done = 1'b0;
  always @(posedge core_clk) begin
    cnt <= gate_drive_n ? 16'h0 : cnt + 16'h1;
    // unpowered part cannot drive; board pull-down holds done low
    if (doneHold)
      done <= 1'b1;
    else
      done <= !gate_drive_n && doneAfter != 16'h0 &&
        ((cnt >= doneAfter && cnt < doneAfter + 16'h6) ||
         (cnt >= doneAfter + 16'h28 && cnt < doneAfter + 16'h2E));
  end
endmodule

/* File: testbench/test_power_gating_interval_timer.sv */
`define CHK(nm, e, g) begin checkCount++; if ((e) !== (g)) begin errTotal++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module test_power_gating_interval_timer;
  timeunit 1ns;
  timeprecision 1ps;
  // one ms tick every 10 cycles keeps intervals short
  localparam int TickCyc = 10;
  logic                   core_clk    = 1'b0;
  logic                   resetn      = 1'b0;
  logic                   mode_select = 1'b1;
  logic                   manualPin   = 1'b0;
  logic                   doneHold    = 1'b0;
  logic [15:0]            doneAfter   = 16'h0;
  pgt_pkg::pgt_interval_t digitised   = '0;
  logic                   done;
  logic                   readActive;
  logic                   readRestart;
  logic                   gate_drive_n;
  int                     errTotal    = 0;
  int                     checkCount  = 0;

  initial forever #12.5 core_clk = ~core_clk;

  pgt_timer #(.TICK_CYC(TickCyc)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .mode_select(mode_select), .done(done),
    .interval_set_manual_on(manualPin), .digitised(digitised), .readActive(readActive),
    .readRestart(readRestart), .gate_drive_n(gate_drive_n));

  pgt_mcu_model mcu_u (.core_clk(core_clk), .gate_drive_n(gate_drive_n),
    .doneAfter(doneAfter), .doneHold(doneHold), .done(done));

  task automatic test_done();
    if (errTotal == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic start(input logic md, input logic hold, input logic [15:0] da);
    @(negedge core_clk);
    resetn = 1'b0;
    mode_select = md;
    doneHold = hold;
    doneAfter = da;
    digitised = '0;
    manualPin = 1'b0;
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
  endtask

  task automatic giveCode();
    digitised = '{code: 17'h1, valid: 1'b1};
  endtask

  task automatic waitGate(input logic lvl, input int maxc, input bit must, output int n);
    n = 0;
    while (gate_drive_n !== lvl && n < maxc) begin
      @(negedge core_clk);
      n++;
    end
    if (must && n >= maxc) begin
      errTotal++;
      $display("mismatch gate wait exp %0h got timeout", lvl);
      test_done();
    end
  endtask

  task automatic tTimer();
    int n;
    int m;
    start(1'b1, 1'b0, 16'h0);
    repeat (20) @(negedge core_clk);
    `CHK("gateIdle", 1'b1, gate_drive_n)
    giveCode();
    waitGate(1'b0, 10, 1, n);
    `CHK("launch", 1'b1, n <= 3)
    `CHK("readEnd", 1'b0, readActive)
    waitGate(1'b1, 600, 1, n);
    `CHK("lowLen", 1'b1, n inside {[480:520]})
    waitGate(1'b0, 600, 1, m);
    `CHK("period", 1'b1, n + m inside {[980:1020]})
    repeat (100) @(negedge core_clk);
    manualPin = 1'b1;
    repeat (250) @(negedge core_clk);
    manualPin = 1'b0;
    waitGate(1'b1, 600, 1, n);
    `CHK("manualWhileOn", 1'b1, n + 350 inside {[480:520]})
  endtask

  task automatic tDone();
    int n;
    int m;
    start(1'b1, 1'b0, 16'h64);
    giveCode();
    waitGate(1'b0, 10, 1, n);
    waitGate(1'b1, 600, 1, n);
    `CHK("doneCut", 1'b1, n inside {[100:112]})
    waitGate(1'b0, 1100, 1, m);
    `CHK("donePeriod", 1'b1, n + m inside {[980:1020]})
    start(1'b1, 1'b1, 16'h0);
    giveCode();
    waitGate(1'b0, 10, 1, n);
    waitGate(1'b1, 600, 1, n);
    `CHK("doneLevel", 1'b1, n inside {[480:520]})
  endtask

  task automatic tOneShot();
    int n;
    int m;
    start(1'b0, 1'b0, 16'h3C);
    n = 0;
    while (readActive === 1'b1 && n < 1300) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("readLimit", 1'b1, n inside {[1180:1220]})
    waitGate(1'b0, 10, 1, m);
    waitGate(1'b1, 600, 1, n);
    `CHK("oneDone", 1'b1, n inside {[60:72]})
    waitGate(1'b0, 1500, 0, n);
    `CHK("oneOnly", 1500, n)
    manualPin = 1'b1;
    repeat (100) @(negedge core_clk);
    manualPin = 1'b0;
    waitGate(1'b0, 600, 0, n);
    `CHK("glitch", 600, n)
    manualPin = 1'b1;
    waitGate(1'b0, 310, 1, n);
    `CHK("manualOn", 1'b1, n >= 190)
    waitGate(1'b1, 500, 0, m);
    `CHK("manualHold", 500, m)
    manualPin = 1'b0;
    waitGate(1'b1, 900, 1, n);
    `CHK("manualWin", 1'b1, n inside {[600:800]})
  endtask

  task automatic tAbort();
    int n;
    logic seen;
    seen = 1'b0;
    start(1'b1, 1'b0, 16'h0);
    repeat (20) @(negedge core_clk);
    manualPin = 1'b1;
    repeat (60) begin
      @(negedge core_clk);
      seen = seen | readRestart;
    end
    `CHK("restart", 1'b1, seen)
    `CHK("stillRead", 1'b1, readActive)
    `CHK("noManual", 1'b1, gate_drive_n)
    manualPin = 1'b0;
    repeat (30) @(negedge core_clk);
    giveCode();
    waitGate(1'b0, 10, 1, n);
    seen = 1'b0;
    repeat (2000) begin
      @(negedge core_clk);
      seen = seen | readActive;
    end
    `CHK("readOnce", 1'b0, seen)
  endtask

  initial begin
    tTimer();
    tDone();
    tOneShot();
    tAbort();
    test_done();
  end
endmodule
